/* core/st_term_activation.sv */
// terminal-side S/T layer-1 activation and deactivation state machine
// What this block does
// - 0000 powers up, reports 0111
// - 0001 resets, sends INFO 0, acks 0001
// - 0010 single pulses at 2 kHz, acks 0010
// - 0011 continuous pulses at 96 kHz, acks 0011
// - 1000 activates at priority 8
// - 1001 activates at priority 10
// - 1010 closes loop 3, reports 1010 then 1110
// - 1111 forces power-down deactivated state
// - 0000 reported when leaving active or unsynchronised
// - slip reported as 0011
// - slip state resyncs, exits after 0.5 ms
// - 0100 while signal present, not synchronised
// - INFO 2 gives 1000, send INFO 3
// - code violation multiframe reports 1011 four times
// - INFO 4 gives 1100 or 1101 by priority
// - 1111 reported while powered down
// - INFO 0 gives pending deactivation
// - pending activation sends INFO 1, reports power-up
// - any signal gives unsynchronised, stops INFO 1
// - synchronised to active 0.5 ms after INFO 4
`timescale 1ns/1ps

module st_term_activation
    import st_term_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // command and indication channel
    input wire logic [3:0] cmd_code,
    output logic [3:0] ind_code_reg,
    output logic ind_strobe_reg,
    // line side
    input wire line_rx_t line_rx,
    output line_ctl_t line_ctl_reg
);

    localparam int DWELL_W = $clog2(DWELL_CYCLES + 1);
    localparam int PULSE_W = $clog2(SINGLE_PULSE_CYCLES + 1);
    localparam logic [DWELL_W-1:0] DWELL_LAST = DWELL_W'(DWELL_CYCLES - 1);
    localparam logic [PULSE_W-1:0] SINGLE_LAST =
        PULSE_W'(SINGLE_PULSE_CYCLES - 1);
    localparam logic [PULSE_W-1:0] CONT_LAST =
        PULSE_W'(CONT_PULSE_CYCLES - 1);

    // line status arrives from outside the clock domain
    line_rx_t rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_reg;
    fsm_state_t state_reg, state_next;
    logic [3:0] cmd_last_reg;
    logic prio_low_reg;
    logic [DWELL_W-1:0] dwell_reg;
    logic [PULSE_W-1:0] pulse_cnt_reg;
    logic pulse_phase_reg;
    logic cv_seen_reg;
    logic [2:0] cv_left_reg;
    logic [3:0] ind_next;
    logic cmd_new;
    logic dwell_done;

    // a change counts once the second and third stages agree
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_s1_reg <= '0;
            rx_s2_reg <= '0;
            rx_s3_reg <= '0;
            rx_reg <= '0;
        end else begin
            rx_s1_reg <= line_rx;
            rx_s2_reg <= rx_s1_reg;
            rx_s3_reg <= rx_s2_reg;
            for (int i = 0; i < $bits(line_rx_t); i++) begin
                if (rx_s2_reg[i] == rx_s3_reg[i]) begin
                    rx_reg[i] <= rx_s3_reg[i];
                end
            end
        end
    end

    assign cmd_new = (cmd_code != cmd_last_reg);
    assign dwell_done = (dwell_reg == DWELL_LAST);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmd_last_reg <= CMD_RESET_VALUE;
        end else begin
            cmd_last_reg <= cmd_code;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prio_low_reg <= 1'b0;
        end else if (cmd_new && cmd_code == CMD_ACT_HIGH_PRIO) begin
            prio_low_reg <= 1'b0;
        end else if (cmd_new && cmd_code == CMD_ACT_LOW_PRIO) begin
            prio_low_reg <= 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (cmd_new && cmd_code == CMD_FSM_RESET) begin
            state_next = ST_RESET;
        end else if (cmd_new && cmd_code == CMD_SINGLE_PULSE) begin
            state_next = ST_SINGLE_TEST;
        end else if (cmd_new && cmd_code == CMD_CONT_PULSE) begin
            state_next = ST_CONT_TEST;
        end else if (cmd_new && cmd_code == CMD_LOOP_ACT) begin
            state_next = ST_LOOP;
        end else if (cmd_new && cmd_code == CMD_POWER_DOWN) begin
            state_next = ST_POWER_DOWN;
        end else if (cmd_new && cmd_code == CMD_TIMING_REQUEST) begin
            state_next = ST_POWER_UP;
        end else begin
            case (state_reg)
                ST_POWER_DOWN, ST_POWER_UP: begin
                    if (cmd_new && (cmd_code == CMD_ACT_HIGH_PRIO ||
                                    cmd_code == CMD_ACT_LOW_PRIO)) begin
                        state_next = ST_PEND_ACT;
                    end else if (rx_reg.signal_present) begin
                        state_next = ST_UNSYNC;
                    end
                end
                ST_PEND_DEACT: begin
                    if (rx_reg.signal_present) begin
                        state_next = ST_UNSYNC;
                    end
                end
                ST_PEND_ACT: begin
                    if (rx_reg.signal_present) begin
                        state_next = ST_UNSYNC;
                    end
                end
                ST_UNSYNC: begin
                    if (rx_reg.info0) begin
                        state_next = ST_PEND_DEACT;
                    end else if (rx_reg.synced && rx_reg.info4) begin
                        state_next = ST_SYNC;
                    end else if (rx_reg.synced && rx_reg.info2) begin
                        state_next = ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    if (rx_reg.info0) begin
                        state_next = ST_PEND_DEACT;
                    end else if (!rx_reg.synced) begin
                        state_next = ST_UNSYNC;
                    end else if (rx_reg.info4 && dwell_done) begin
                        state_next = ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (rx_reg.info0) begin
                        state_next = ST_PEND_DEACT;
                    end else if (!rx_reg.synced) begin
                        state_next = ST_UNSYNC;
                    end else if (rx_reg.slip) begin
                        state_next = ST_SLIP;
                    end
                end
                ST_SLIP: begin
                    if (dwell_done) begin
                        state_next = ST_ACTIVE;
                    end
                end
                ST_RESET, ST_SINGLE_TEST, ST_CONT_TEST, ST_LOOP: begin
                    state_next = state_reg;
                end
                default: state_next = ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // one timer serves the INFO 4 wait, slip dwell and loop closing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dwell_reg <= '0;
        end else if (state_next != state_reg) begin
            dwell_reg <= '0;
        end else if ((state_reg == ST_SYNC && rx_reg.info4) ||
                     state_reg == ST_SLIP || state_reg == ST_LOOP) begin
            if (!dwell_done) begin
                dwell_reg <= dwell_reg + 1'b1;
            end
        end else begin
            dwell_reg <= '0;
        end
    end

    // test pulse generator, polarity alternates each pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulse_cnt_reg <= '0;
            pulse_phase_reg <= 1'b0;
        end else if ((state_reg == ST_SINGLE_TEST &&
                      pulse_cnt_reg == SINGLE_LAST) ||
                     (state_reg == ST_CONT_TEST &&
                      pulse_cnt_reg >= CONT_LAST)) begin
            pulse_cnt_reg <= '0;
            pulse_phase_reg <= ~pulse_phase_reg;
        end else if (state_reg == ST_SINGLE_TEST ||
                     state_reg == ST_CONT_TEST) begin
            pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
        end else begin
            pulse_cnt_reg <= '0;
        end
    end

    // code violation bookkeeping per multiframe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cv_seen_reg <= 1'b0;
            cv_left_reg <= '0;
        end else begin
            if (rx_reg.multiframe_end) begin
                cv_seen_reg <= 1'b0;
            end else if (rx_reg.code_violation) begin
                cv_seen_reg <= 1'b1;
            end
            // slots count down even while the boundary level stands
            if (rx_reg.multiframe_end &&
                (cv_seen_reg || rx_reg.code_violation)) begin
                cv_left_reg <= 3'(CODE_VIOL_REPEATS);
            end else if (cv_left_reg != 3'h0 &&
                         ind_code_reg == IND_CODE_VIOL && ind_strobe_reg) begin
                cv_left_reg <= cv_left_reg - 1'b1;
            end
        end
    end

    always_comb begin
        case (state_reg)
            ST_RESET: ind_next = IND_RESET_ACK;
            ST_SINGLE_TEST: ind_next = IND_SINGLE_ACK;
            ST_CONT_TEST: ind_next = IND_CONT_ACK;
            ST_POWER_DOWN: ind_next = IND_POWERED_DOWN;
            ST_POWER_UP, ST_PEND_ACT: ind_next = IND_POWERED_UP;
            ST_PEND_DEACT: ind_next = IND_DEACT_REQ;
            ST_UNSYNC: ind_next = IND_UNSYNC;
            ST_SYNC: ind_next = IND_ACT_REQ;
            ST_ACTIVE: ind_next = prio_low_reg ? IND_ACT_LOW
                                               : IND_ACT_HIGH;
            ST_SLIP: ind_next = IND_SLIP;
            ST_LOOP: ind_next = dwell_done ? IND_LOOP_ACTIVE
                                           : IND_LOOP_CLOSED;
            default: ind_next = IND_RESET_ACK;
        endcase
        if (cv_left_reg != 3'h0 && state_reg != ST_RESET) begin
            ind_next = IND_CODE_VIOL;
        end
    end

    // strobe marks each fresh indication; repeats of 1011 re-strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ind_code_reg <= IND_RESET_ACK;
            ind_strobe_reg <= 1'b0;
        end else begin
            ind_code_reg <= ind_next;
            ind_strobe_reg <= (ind_next != ind_code_reg) ||
                (ind_next == IND_CODE_VIOL && !ind_strobe_reg);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            line_ctl_reg <= '0;
        end else begin
            line_ctl_reg.wake_enable <= (state_next != ST_RESET);
            line_ctl_reg.loop_closed <= (state_next == ST_LOOP);
            line_ctl_reg.pulse_pos <= pulse_phase_reg &&
                (state_reg == ST_SINGLE_TEST || state_reg == ST_CONT_TEST);
            line_ctl_reg.pulse_neg <= !pulse_phase_reg &&
                (state_reg == ST_SINGLE_TEST || state_reg == ST_CONT_TEST);
            case (state_next)
                ST_PEND_ACT: line_ctl_reg.info <= TX_INFO1;
                ST_SYNC, ST_ACTIVE, ST_SLIP:
                    line_ctl_reg.info <= TX_INFO3;
                ST_SINGLE_TEST: line_ctl_reg.info <= TX_SINGLE_PULSE;
                ST_CONT_TEST: line_ctl_reg.info <= TX_CONT_PULSE;
                default: line_ctl_reg.info <= TX_INFO0;
            endcase
        end
    end

    property p_reset_ack;
        @(posedge clock) disable iff (!rst_n)
        (cmd_new && cmd_code == CMD_FSM_RESET) |-> ##2
        (ind_code_reg == IND_RESET_ACK && line_ctl_reg.info == TX_INFO0);
    endproperty
    a_reset_ack: assert property (p_reset_ack)
        else $error("reset command not acknowledged");

    property p_power_up;
        @(posedge clock) disable iff (!rst_n)
        (cmd_new && cmd_code == CMD_TIMING_REQUEST) |-> ##2
        (ind_code_reg == IND_POWERED_UP || ind_code_reg == IND_CODE_VIOL);
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("power-up indication missing");

    property p_power_down;
        @(posedge clock) disable iff (!rst_n)
        (cmd_new && cmd_code == CMD_POWER_DOWN) |=> state_reg == ST_POWER_DOWN;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down command ignored");

    property p_single_test;
        @(posedge clock) disable iff (!rst_n)
        (cmd_new && cmd_code == CMD_SINGLE_PULSE) |-> ##2
        line_ctl_reg.info == TX_SINGLE_PULSE;
    endproperty
    a_single_test: assert property (p_single_test)
        else $error("single pulse test not entered");

    property p_cont_test;
        @(posedge clock) disable iff (!rst_n)
        (cmd_new && cmd_code == CMD_CONT_PULSE) |=>
        state_reg == ST_CONT_TEST;
    endproperty
    a_cont_test: assert property (p_cont_test)
        else $error("continuous pulse test not entered");

    property p_slip_leaves;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_SLIP && dwell_done && !cmd_new) |=>
        state_reg == ST_ACTIVE;
    endproperty
    a_slip_leaves: assert property (p_slip_leaves)
        else $error("slip state not left");

    property p_pend_act_info1;
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_PEND_ACT && $past(state_reg) == ST_PEND_ACT |->
        line_ctl_reg.info == TX_INFO1;
    endproperty
    a_pend_act_info1: assert property (p_pend_act_info1)
        else $error("INFO 1 not sent in pending activation");

    property p_active_prio;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_ACTIVE && cv_left_reg == 3'h0) |=>
        (ind_code_reg == (prio_low_reg ? IND_ACT_LOW : IND_ACT_HIGH) ||
         state_reg != ST_ACTIVE || $past(prio_low_reg) != prio_low_reg);
    endproperty
    a_active_prio: assert property (p_active_prio)
        else $error("wrong priority indication");

    property p_strobe_change;
        @(posedge clock) disable iff (!rst_n)
        (ind_code_reg != $past(ind_code_reg)) |-> ind_strobe_reg;
    endproperty
    a_strobe_change: assert property (p_strobe_change)
        else $error("indication change without strobe");

    c_activation: cover property (@(posedge clock) disable iff (!rst_n)
        state_reg == ST_SYNC ##1 state_reg == ST_ACTIVE);
    c_slip: cover property (@(posedge clock) disable iff (!rst_n)
        state_reg == ST_SLIP ##1 state_reg == ST_ACTIVE);
    c_loop: cover property (@(posedge clock) disable iff (!rst_n)
        ind_code_reg == IND_LOOP_ACTIVE);
    c_code_viol: cover property (@(posedge clock) disable iff (!rst_n)
        ind_code_reg == IND_CODE_VIOL);

endmodule

/* core/st_term_pkg.sv */
// constants, codes and carrier types for the terminal-side activation machine
package st_term_pkg;

    // command codes from the controller
    localparam logic [3:0] CMD_TIMING_REQUEST = 4'h0;
    localparam logic [3:0] CMD_FSM_RESET = 4'h1;
    localparam logic [3:0] CMD_SINGLE_PULSE = 4'h2;
    localparam logic [3:0] CMD_CONT_PULSE = 4'h3;
    localparam logic [3:0] CMD_ACT_HIGH_PRIO = 4'h8;
    localparam logic [3:0] CMD_ACT_LOW_PRIO = 4'h9;
    localparam logic [3:0] CMD_LOOP_ACT = 4'hA;
    localparam logic [3:0] CMD_POWER_DOWN = 4'hF;

    // indication codes to the controller
    localparam logic [3:0] IND_DEACT_REQ = 4'h0;
    localparam logic [3:0] IND_RESET_ACK = 4'h1;
    localparam logic [3:0] IND_SINGLE_ACK = 4'h2;
    localparam logic [3:0] IND_CONT_ACK = 4'h3;
    localparam logic [3:0] IND_SLIP = 4'h3;
    localparam logic [3:0] IND_UNSYNC = 4'h4;
    localparam logic [3:0] IND_POWERED_UP = 4'h7;
    localparam logic [3:0] IND_ACT_REQ = 4'h8;
    localparam logic [3:0] IND_LOOP_CLOSED = 4'hA;
    localparam logic [3:0] IND_CODE_VIOL = 4'hB;
    localparam logic [3:0] IND_ACT_HIGH = 4'hC;
    localparam logic [3:0] IND_ACT_LOW = 4'hD;
    localparam logic [3:0] IND_LOOP_ACTIVE = 4'hE;
    localparam logic [3:0] IND_POWERED_DOWN = 4'hF;

    // timing at a 100 ns clock
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int DWELL_TIME_US = 500;
    localparam int DWELL_CYCLES = DWELL_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam int SINGLE_PULSE_HZ = 2000;
    localparam int SINGLE_PULSE_CYCLES =
        1000000000 / CLOCK_PERIOD_NS / SINGLE_PULSE_HZ;
    localparam int CONT_PULSE_HZ = 96000;
    localparam int CONT_PULSE_CYCLES =
        1000000000 / CLOCK_PERIOD_NS / CONT_PULSE_HZ;
    localparam int CODE_VIOL_REPEATS = 4;
    localparam logic [3:0] CMD_RESET_VALUE = 4'h1;

    // line transmit states
    typedef enum logic [2:0] {
        TX_INFO0 = 3'b000,
        TX_INFO1 = 3'b001,
        TX_INFO3 = 3'b011,
        TX_SINGLE_PULSE = 3'b100,
        TX_CONT_PULSE = 3'b101
    } line_tx_t;

    typedef enum logic [3:0] {
        ST_RESET = 4'b0000,
        ST_POWER_DOWN = 4'b0001,
        ST_POWER_UP = 4'b0010,
        ST_PEND_DEACT = 4'b0011,
        ST_PEND_ACT = 4'b0100,
        ST_UNSYNC = 4'b0101,
        ST_SYNC = 4'b0110,
        ST_ACTIVE = 4'b0111,
        ST_SLIP = 4'b1000,
        ST_SINGLE_TEST = 4'b1001,
        ST_CONT_TEST = 4'b1010,
        ST_LOOP = 4'b1011
    } fsm_state_t;

    // receiver status from the line
    typedef struct packed {
        logic signal_present;
        logic synced;
        logic info0;
        logic info2;
        logic info4;
        logic code_violation;
        logic multiframe_end;
        logic slip;
    } line_rx_t;

    // what goes back out to the line
    typedef struct packed {
        line_tx_t info;
        logic pulse_pos;
        logic pulse_neg;
        logic wake_enable;
        logic loop_closed;
    } line_ctl_t;

endpackage

/* dv/st_line_partner.sv */
// network-termination model driving the receiver status toward the block
`timescale 1ns/1ps

module st_line_partner
    import st_term_pkg::*;
(
    // clock
    input wire logic clock,
    // scenario control from the bench
    input wire logic [1:0] mode,
    input wire logic slip_req,
    input wire logic viol_req,
    // receiver status
    output line_rx_t line_rx
);
    int viol_cnt = 0;

    // violation burst, then a multiframe boundary, each held 8 cycles
    always @(posedge clock) begin
        if (viol_req && viol_cnt == 0) begin
            viol_cnt <= 16;
        end else if (viol_cnt > 0) begin
            viol_cnt <= viol_cnt - 1;
        end
    end

    // mode 0 silent, 1 unframed signal, 2 framed INFO 2, 3 framed INFO 4
    always_comb begin
        line_rx = '0;
        line_rx.info0 = (mode == 2'h0);
        line_rx.signal_present = (mode != 2'h0);
        line_rx.synced = mode[1];
        line_rx.info2 = (mode == 2'h2);
        line_rx.info4 = (mode == 2'h3);
        line_rx.slip = slip_req;
        line_rx.code_violation = (viol_cnt > 8);
        line_rx.multiframe_end = (viol_cnt > 0 && viol_cnt <= 8);
    end
endmodule

/* dv/st_line_terminal_activation_fsm_tb_top.sv */
// self-checking bench for the terminal-side activation machine
`timescale 1ns/1ps

module st_line_terminal_activation_fsm_tb_top
    import st_term_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] cmd_code = CMD_FSM_RESET;
    logic [3:0] ind_code_reg;
    logic ind_strobe_reg;
    line_rx_t line_rx;
    line_ctl_t line_ctl_reg;
    logic [1:0] mode = 2'h0;
    logic slip_req = 1'b0;
    logic viol_req = 1'b0;
    int err_total = 0;
    int n_checks = 0;
    int n_strobe = 0;
    int n_viol = 0;
    logic seen_pos = 1'b0;
    logic seen_neg = 1'b0;

    initial begin
        forever #50 clock = ~clock;
    end

    st_term_activation u_dut (
        .clock(clock),
        .rst_n(rst_n),
        .cmd_code(cmd_code),
        .ind_code_reg(ind_code_reg),
        .ind_strobe_reg(ind_strobe_reg),
        .line_rx(line_rx),
        .line_ctl_reg(line_ctl_reg)
    );

    st_line_partner u_partner (
        .clock(clock),
        .mode(mode),
        .slip_req(slip_req),
        .viol_req(viol_req),
        .line_rx(line_rx)
    );

    // strobe and pulse monitors; n_viol and the pulse flags are cleared by the scenarios, n_strobe never
    always @(posedge clock) begin
        if (ind_strobe_reg === 1'b1) begin
            n_strobe <= n_strobe + 1;
            if (ind_code_reg === IND_CODE_VIOL) begin
                n_viol <= n_viol + 1;
            end
        end
        if (line_ctl_reg.pulse_pos === 1'b1) seen_pos <= 1'b1;
        if (line_ctl_reg.pulse_neg === 1'b1) seen_neg <= 1'b1;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic send_cmd(input logic [3:0] c);
        @(negedge clock);
        cmd_code = c;
    endtask

    // bounded wait, then the comparison itself
    task automatic expect_ind(input logic [3:0] exp, input int limit);
        int i;
        i = 0;
        while (ind_code_reg !== exp && i < limit) begin
            @(negedge clock);
            i++;
        end
        check({4'h0, ind_code_reg}, {4'h0, exp});
    endtask

    task automatic check_info(input line_tx_t exp);
        check({5'h0, line_ctl_reg.info}, {5'h0, exp});
    endtask

    task automatic t_reset_and_power_up();
        idle(20);
        check({4'h0, ind_code_reg}, {4'h0, IND_RESET_ACK});
        check({1'b0, line_ctl_reg}, 8'h00);
        check(8'(n_strobe), 8'h00);
        send_cmd(CMD_TIMING_REQUEST);
        expect_ind(IND_POWERED_UP, 10);
        idle(20);
        check({7'h0, line_ctl_reg.wake_enable}, 8'h01);
        check(8'(n_strobe), 8'h01);
    endtask

    // terminal activation through INFO 1, INFO 2, INFO 4
    task automatic t_activate(input logic [3:0] c, input logic [3:0] ind);
        send_cmd(c);
        idle(10);
        check_info(TX_INFO1);
        check({4'h0, ind_code_reg}, {4'h0, IND_POWERED_UP});
        mode = 2'h1;
        expect_ind(IND_UNSYNC, 20);
        check_info(TX_INFO0);
        mode = 2'h2;
        expect_ind(IND_ACT_REQ, 20);
        check_info(TX_INFO3);
        mode = 2'h3;
        idle(3000);
        check({4'h0, ind_code_reg}, {4'h0, IND_ACT_REQ});
        expect_ind(ind, 3000);
    endtask

    task automatic t_slip_and_violation();
        slip_req = 1'b1;
        idle(10);
        slip_req = 1'b0;
        expect_ind(IND_SLIP, 20);
        idle(4000);
        check({4'h0, ind_code_reg}, {4'h0, IND_SLIP});
        expect_ind(IND_ACT_HIGH, 2000);
        n_viol = 0;
        viol_req = 1'b1;
        idle(2);
        viol_req = 1'b0;
        expect_ind(IND_CODE_VIOL, 40);
        expect_ind(IND_ACT_HIGH, 6000);
        check(8'(n_viol), 8'(CODE_VIOL_REPEATS));
    endtask

    task automatic t_deactivate();
        mode = 2'h0;
        expect_ind(IND_DEACT_REQ, 20);
        send_cmd(CMD_ACT_LOW_PRIO);
        idle(20);
        check({4'h0, ind_code_reg}, {4'h0, IND_DEACT_REQ});
        send_cmd(CMD_POWER_DOWN);
        expect_ind(IND_POWERED_DOWN, 10);
        send_cmd(CMD_TIMING_REQUEST);
        expect_ind(IND_POWERED_UP, 10);
    endtask

    task automatic t_loop_and_tests();
        mode = 2'h0;
        send_cmd(CMD_LOOP_ACT);
        idle(2);
        check({7'h0, line_ctl_reg.loop_closed}, 8'h01);
        expect_ind(IND_LOOP_CLOSED, 5);
        expect_ind(IND_LOOP_ACTIVE, 6000);
        send_cmd(CMD_SINGLE_PULSE);
        expect_ind(IND_SINGLE_ACK, 10);
        check_info(TX_SINGLE_PULSE);
        send_cmd(CMD_TIMING_REQUEST);
        expect_ind(IND_POWERED_UP, 10);
        send_cmd(CMD_CONT_PULSE);
        expect_ind(IND_CONT_ACK, 10);
        check_info(TX_CONT_PULSE);
        seen_pos = 1'b0;
        seen_neg = 1'b0;
        idle(3 * CONT_PULSE_CYCLES);
        check({6'h0, seen_pos, seen_neg}, 8'h03);
        send_cmd(CMD_TIMING_REQUEST);
        expect_ind(IND_POWERED_UP, 10);
        send_cmd(CMD_FSM_RESET);
        expect_ind(IND_RESET_ACK, 10);
        idle(2);
        check({1'b0, line_ctl_reg}, 8'h00);
        mode = 2'h2;
        idle(20);
        check({4'h0, ind_code_reg}, {4'h0, IND_RESET_ACK});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // whole run is near 21000 cycles
    initial begin
        #(80000 * 100);
        err_total++;
        wrap_up();
    end

    initial begin
        idle(10);
        rst_n = 1'b1;
        t_reset_and_power_up();
        t_activate(CMD_ACT_HIGH_PRIO, IND_ACT_HIGH);
        t_slip_and_violation();
        t_deactivate();
        t_activate(CMD_ACT_LOW_PRIO, IND_ACT_LOW);
        t_loop_and_tests();
        wrap_up();
    end
endmodule
